/* File: rtl/lcdcd_pkg.sv */
/*
  Constants, opcode patterns, reset values and state encoding for the
  LCD driver command decoder. Assumes one 125 MHz clock domain.
*/
// Behaviour
// - command 1010111x switches display off (bit0=0) or on (bit0=1).
// - start line set by 011 (upper 3 bits) and 010 (lower 4 bits) commands.
// - command 1011xxxx loads low nibble as RAM page address.
// - column loaded by 0001 (upper nibble) and 0000 (lower nibble) commands.
// - command-side read returns status in upper nibble, lower nibble zero.
// - data-side write stores byte in RAM; data-side read returns RAM byte.
// - command 1010000x selects forward or reversed column-to-segment mapping.
// - command 1010011x selects normal or inverted pixel polarity.
// - command 1010010x selects normal display or all dots on.
// - command 1010001x selects bias 1/11 (bit0=0) or 1/9 (bit0=1).
// - command 11100000 enters read-modify-write: column +1 on write, unchanged on read.
// - command 11101110 leaves read-modify-write mode.
// - command 1100xxxx sets common scan direction from bit 3.
// - command 00101xxx loads supply circuit operating state.
// - command 00100xxx loads resistor ratio for top drive voltage.
// - command 10000001 then next byte's low six bits set top drive voltage.
// - command 1010110x: indicator off, or on awaiting a blink-state byte.
// - command 1101xxxx selects frame (bit3=0) or line (bit3=1) inversion.
// - after line inversion, next byte's low five bits set inverted line count.
// - power save is entered through display-off plus all-dots-on.
// - command 11100011 is a no-op.
// - after indicator on, only the blink-state byte is accepted.
// - after line inversion, only the line-count byte is accepted.
// - voltage-level mode ends once its level byte is written.
// - all-on while display off enters standby (indicator on) or sleep.
package lcdcd_pkg;

  localparam int SYNC_STAGES = 2;

  // opcode value and mask pairs
  localparam logic [7:0] OP_DISP_V = 8'hAE, OP_DISP_M = 8'hFE;
  localparam logic [7:0] OP_SLHI_V = 8'h60, OP_SLHI_M = 8'hE0;
  localparam logic [7:0] OP_SLLO_V = 8'h40, OP_SLLO_M = 8'hE0;
  localparam logic [7:0] OP_PAGE_V = 8'hB0, OP_PAGE_M = 8'hF0;
  localparam logic [7:0] OP_COLHI_V = 8'h10, OP_COLHI_M = 8'hF0;
  localparam logic [7:0] OP_COLLO_V = 8'h00, OP_COLLO_M = 8'hF0;
  localparam logic [7:0] OP_MIRROR_V = 8'hA0, OP_MIRROR_M = 8'hFE;
  localparam logic [7:0] OP_INV_V = 8'hA6, OP_INV_M = 8'hFE;
  localparam logic [7:0] OP_ALLON_V = 8'hA4, OP_ALLON_M = 8'hFE;
  localparam logic [7:0] OP_BIAS_V = 8'hA2, OP_BIAS_M = 8'hFE;
  localparam logic [7:0] OP_IND_V = 8'hAC, OP_IND_M = 8'hFE;
  localparam logic [7:0] OP_RMW_V = 8'hE0, OP_EXACT_M = 8'hFF;
  localparam logic [7:0] OP_END_V = 8'hEE;
  localparam logic [7:0] OP_RESET_V = 8'hE2;
  localparam logic [7:0] OP_NOP_V = 8'hE3;
  localparam logic [7:0] OP_VOLT_V = 8'h81;
  localparam logic [7:0] OP_COMMON_V = 8'hC0, OP_COMMON_M = 8'hF0;
  localparam logic [7:0] OP_DRV_V = 8'hD0, OP_DRV_M = 8'hF0;
  localparam logic [7:0] OP_PWR_V = 8'h28, OP_PWR_M = 8'hF8;
  localparam logic [7:0] OP_RATIO_V = 8'h20, OP_RATIO_M = 8'hF8;
  localparam logic [7:0] OP_TEST_V = 8'hF0, OP_TEST_M = 8'hF0;

  // field positions
  localparam int BIT_SEL = 0;
  localparam int BIT_D3 = 3;
  localparam int STAT_MIRROR_BIT = 6;
  localparam int STAT_OFF_BIT = 5;

  // address limits and reset values
  localparam logic [7:0] COL_MAX = 8'h83;
  localparam logic [6:0] RST_START = 7'h00;
  localparam logic [3:0] RST_PAGE = 4'h0;
  localparam logic [7:0] RST_COL = 8'h00;
  localparam logic [2:0] RST_PWR = 3'h0;
  localparam logic [2:0] RST_RATIO = 3'h0;
  localparam logic [5:0] RST_VOLT = 6'h20;
  localparam logic [1:0] RST_BLINK = 2'h0;
  localparam logic [4:0] RST_LINES = 5'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [1:0] {
    LCDCD_IDLE = 2'b00,
    LCDCD_WAIT_VOLT = 2'b01,
    LCDCD_WAIT_IND = 2'b10,
    LCDCD_WAIT_LINE = 2'b11
  } lcdcd_state_e;

  // don't-care bits are masked off before comparing
  function automatic logic lcdcd_match(input logic [7:0] b, input logic [7:0] v, input logic [7:0] m);
    return (b & m) == v;
  endfunction : lcdcd_match

endpackage : lcdcd_pkg

/* File: rtl/lcdcd_sync.sv */
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous levels held for several clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdcd_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
          meta_reg[i] <= INIT[i];
          sync_reg[i] <= INIT[i];
        end else begin
          meta_reg[i] <= async_in[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_reg;
endmodule : lcdcd_sync
`default_nettype wire

/* File: rtl/lcdcd_ram.sv */
/*
  Display data RAM, one byte per page and column, host side only.
  Assumes page in the upper address bits, column in the lower.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdcd_ram (
  // clock
  input wire logic clk_sys_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] wdata_in,
  // read port, combinational so the answer is ready at the strobe edge
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:4095];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  assign rdata_out = mem[addr_in];
endmodule : lcdcd_ram
`default_nettype wire

/* File: rtl/lcdcd_decoder.sv */
/*
  Command decoder of a bitmap LCD driver: parallel host port, command
  interpretation, RAM addressing and display mode outputs.
  Assumes host pins are asynchronous and held for several clocks per strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdcd_decoder (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // host port pins
  input wire logic [7:0] bus_data_in,
  input wire logic cmd_data_select_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe_n_out,
  // display modes
  output logic display_on_out,
  output logic [6:0] start_line_out,
  output logic [3:0] page_out,
  output logic [7:0] column_out,
  output logic segment_reverse_out,
  output logic pixel_invert_out,
  output logic all_on_out,
  output logic bias_ninth_out,
  output logic rmw_out,
  output logic common_reverse_out,
  // supply and drive
  output logic [2:0] power_ctrl_out,
  output logic [2:0] resistor_ratio_out,
  output logic [5:0] top_drive_voltage_out,
  output logic line_inversion_out,
  output logic [4:0] inverted_lines_out,
  // indicator and power save
  output logic indicator_on_out,
  output logic [1:0] indicator_blink_out,
  output logic sleep_out,
  output logic standby_out
);
  logic [7:0] byte_s;
  logic sel_s, rd_n_s, wr_n_s;
  logic rd_n_d_reg, wr_n_d_reg;
  logic wr_edge, rd_edge, wr_cmd, wr_data, rd_cmd, rd_data;
  logic [7:0] ram_rdata;
  logic [7:0] col_inc;

  lcdcd_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_data (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .async_in(bus_data_in),
    .sync_out(byte_s)
  );

  lcdcd_sync #(.WIDTH(3), .INIT(3'h3)) u_sync_ctl (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .async_in({cmd_data_select_in, rd_n_in, wr_n_in}),
    .sync_out({sel_s, rd_n_s, wr_n_s})
  );

  // strobes act once, on the synchronised falling edge
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_n_d_reg <= 1'b1;
      wr_n_d_reg <= 1'b1;
    end else begin
      rd_n_d_reg <= rd_n_s;
      wr_n_d_reg <= wr_n_s;
    end
  end

  assign wr_edge = wr_n_d_reg & ~wr_n_s;
  assign rd_edge = rd_n_d_reg & ~rd_n_s;
  assign wr_cmd = wr_edge & ~sel_s;
  assign wr_data = wr_edge & sel_s;
  assign rd_cmd = rd_edge & ~sel_s;
  assign rd_data = rd_edge & sel_s;
  assign col_inc = (column_out == lcdcd_pkg::COL_MAX) ? lcdcd_pkg::RST_COL : column_out + 8'h01;

  lcdcd_ram u_ram (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(wr_data),
    .addr_in({page_out, column_out}),
    .wdata_in(byte_s),
    .rdata_out(ram_rdata)
  );

  lcdcd_pkg::lcdcd_state_e state_reg, state_next;
  logic disp_next, segment_next, inv_next, allon_next, bias_next, rmw_next, common_next;
  logic line_next, ind_next, sleep_next, standby_next;
  logic [6:0] start_next;
  logic [3:0] page_next;
  logic [7:0] col_next, bus_next;
  logic [2:0] pwr_next, ratio_next;
  logic [5:0] volt_next;
  logic [4:0] lines_next;
  logic [1:0] blink_next;
  logic oe_n_next;

  always_comb begin
    state_next = state_reg;
    disp_next = display_on_out;
    start_next = start_line_out;
    page_next = page_out;
    col_next = column_out;
    segment_next = segment_reverse_out;
    inv_next = pixel_invert_out;
    allon_next = all_on_out;
    bias_next = bias_ninth_out;
    rmw_next = rmw_out;
    common_next = common_reverse_out;
    pwr_next = power_ctrl_out;
    ratio_next = resistor_ratio_out;
    volt_next = top_drive_voltage_out;
    line_next = line_inversion_out;
    lines_next = inverted_lines_out;
    ind_next = indicator_on_out;
    blink_next = indicator_blink_out;
    bus_next = bus_data_out;
    oe_n_next = rd_n_s | rd_n_d_reg; // drive only while strobe held
    if (wr_data) begin
      col_next = col_inc;
    end else if (rd_data) begin
      bus_next = ram_rdata;
      if (!rmw_out) begin
        col_next = col_inc;
      end
    end else if (rd_cmd) begin
      bus_next = 8'h00;
      bus_next[lcdcd_pkg::STAT_MIRROR_BIT] = segment_reverse_out;
      bus_next[lcdcd_pkg::STAT_OFF_BIT] = ~display_on_out;
    end else if (wr_cmd) begin
      case (state_reg)
        lcdcd_pkg::LCDCD_WAIT_VOLT: begin
          volt_next = byte_s[5:0];
          state_next = lcdcd_pkg::LCDCD_IDLE;
        end
        lcdcd_pkg::LCDCD_WAIT_IND: begin
          blink_next = byte_s[1:0];
          state_next = lcdcd_pkg::LCDCD_IDLE;
        end
        lcdcd_pkg::LCDCD_WAIT_LINE: begin
          lines_next = byte_s[4:0];
          state_next = lcdcd_pkg::LCDCD_IDLE;
        end
        default: begin
          if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_DISP_V, lcdcd_pkg::OP_DISP_M)) begin
            disp_next = byte_s[lcdcd_pkg::BIT_SEL];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_SLHI_V, lcdcd_pkg::OP_SLHI_M)) begin
            start_next[6:4] = byte_s[2:0];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_SLLO_V, lcdcd_pkg::OP_SLLO_M)) begin
            start_next[3:0] = byte_s[3:0];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_PAGE_V, lcdcd_pkg::OP_PAGE_M)) begin
            page_next = byte_s[3:0];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_COLHI_V, lcdcd_pkg::OP_COLHI_M)) begin
            col_next[7:4] = byte_s[3:0];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_COLLO_V, lcdcd_pkg::OP_COLLO_M)) begin
            col_next[3:0] = byte_s[3:0];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_MIRROR_V, lcdcd_pkg::OP_MIRROR_M)) begin
            segment_next = byte_s[lcdcd_pkg::BIT_SEL];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_INV_V, lcdcd_pkg::OP_INV_M)) begin
            inv_next = byte_s[lcdcd_pkg::BIT_SEL];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_ALLON_V, lcdcd_pkg::OP_ALLON_M)) begin
            allon_next = byte_s[lcdcd_pkg::BIT_SEL];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_BIAS_V, lcdcd_pkg::OP_BIAS_M)) begin
            bias_next = byte_s[lcdcd_pkg::BIT_SEL];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_IND_V, lcdcd_pkg::OP_IND_M)) begin
            ind_next = byte_s[lcdcd_pkg::BIT_SEL];
            if (byte_s[lcdcd_pkg::BIT_SEL]) begin
              state_next = lcdcd_pkg::LCDCD_WAIT_IND;
            end
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_RMW_V, lcdcd_pkg::OP_EXACT_M)) begin
            rmw_next = 1'b1;
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_END_V, lcdcd_pkg::OP_EXACT_M)) begin
            rmw_next = 1'b0;
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_RESET_V, lcdcd_pkg::OP_EXACT_M)) begin
            // internal reset: addressing and settings back to defaults except display on/off, pixel inversion, all-on, line inversion and inverted line count; RAM kept
            start_next = lcdcd_pkg::RST_START;
            page_next = lcdcd_pkg::RST_PAGE;
            col_next = lcdcd_pkg::RST_COL;
            segment_next = 1'b0;
            bias_next = 1'b0;
            rmw_next = 1'b0;
            common_next = 1'b0;
            pwr_next = lcdcd_pkg::RST_PWR;
            ratio_next = lcdcd_pkg::RST_RATIO;
            volt_next = lcdcd_pkg::RST_VOLT;
            ind_next = 1'b0;
            blink_next = lcdcd_pkg::RST_BLINK;
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_VOLT_V, lcdcd_pkg::OP_EXACT_M)) begin
            state_next = lcdcd_pkg::LCDCD_WAIT_VOLT;
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_COMMON_V, lcdcd_pkg::OP_COMMON_M)) begin
            common_next = byte_s[lcdcd_pkg::BIT_D3];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_DRV_V, lcdcd_pkg::OP_DRV_M)) begin
            line_next = byte_s[lcdcd_pkg::BIT_D3];
            if (byte_s[lcdcd_pkg::BIT_D3]) begin
              state_next = lcdcd_pkg::LCDCD_WAIT_LINE;
            end
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_PWR_V, lcdcd_pkg::OP_PWR_M)) begin
            pwr_next = byte_s[2:0];
          end else if (lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_RATIO_V, lcdcd_pkg::OP_RATIO_M)) begin
            ratio_next = byte_s[2:0];
          end
          // nop, test and unlisted bytes fall through unchanged
        end
      endcase
    end
    // power save follows the compound state; indicator picks standby over sleep
    standby_next = ~disp_next & allon_next & ind_next;
    sleep_next = ~disp_next & allon_next & ~ind_next;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_reg <= lcdcd_pkg::LCDCD_IDLE;
      display_on_out <= 1'b0;
      start_line_out <= lcdcd_pkg::RST_START;
      page_out <= lcdcd_pkg::RST_PAGE;
      column_out <= lcdcd_pkg::RST_COL;
      segment_reverse_out <= 1'b0;
      pixel_invert_out <= 1'b0;
      all_on_out <= 1'b0;
      bias_ninth_out <= 1'b0;
      rmw_out <= 1'b0;
      common_reverse_out <= 1'b0;
      power_ctrl_out <= lcdcd_pkg::RST_PWR;
      resistor_ratio_out <= lcdcd_pkg::RST_RATIO;
      top_drive_voltage_out <= lcdcd_pkg::RST_VOLT;
      line_inversion_out <= 1'b0;
      inverted_lines_out <= lcdcd_pkg::RST_LINES;
      indicator_on_out <= 1'b0;
      indicator_blink_out <= lcdcd_pkg::RST_BLINK;
      sleep_out <= 1'b0;
      standby_out <= 1'b0;
      bus_data_out <= lcdcd_pkg::RST_BYTE;
      bus_data_oe_n_out <= 1'b1;
    end else begin
      state_reg <= state_next;
      display_on_out <= disp_next;
      start_line_out <= start_next;
      page_out <= page_next;
      column_out <= col_next;
      segment_reverse_out <= segment_next;
      pixel_invert_out <= inv_next;
      all_on_out <= allon_next;
      bias_ninth_out <= bias_next;
      rmw_out <= rmw_next;
      common_reverse_out <= common_next;
      power_ctrl_out <= pwr_next;
      resistor_ratio_out <= ratio_next;
      top_drive_voltage_out <= volt_next;
      line_inversion_out <= line_next;
      inverted_lines_out <= lines_next;
      indicator_on_out <= ind_next;
      indicator_blink_out <= blink_next;
      sleep_out <= sleep_next;
      standby_out <= standby_next;
      bus_data_out <= bus_next;
      bus_data_oe_n_out <= oe_n_next;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  logic idle_cmd;
  assign idle_cmd = wr_cmd & (state_reg == lcdcd_pkg::LCDCD_IDLE);

  property p_disp;
    idle_cmd && lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_DISP_V, lcdcd_pkg::OP_DISP_M)
      |=> display_on_out == $past(byte_s[0]);
  endproperty
  a_disp: assert property (p_disp) else $error("display on/off not taken");

  property p_start_hi;
    idle_cmd && lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_SLHI_V, lcdcd_pkg::OP_SLHI_M)
      |=> start_line_out[6:4] == $past(byte_s[2:0]) && $stable(start_line_out[3:0]);
  endproperty
  a_start_hi: assert property (p_start_hi) else $error("start line upper bits wrong");

  property p_page;
    idle_cmd && lcdcd_pkg::lcdcd_match(byte_s, lcdcd_pkg::OP_PAGE_V, lcdcd_pkg::OP_PAGE_M)
      |=> page_out == $past(byte_s[3:0]);
  endproperty
  a_page: assert property (p_page) else $error("page address wrong");

  property p_status;
    rd_cmd |=> bus_data_out[3:0] == 4'h0 && bus_data_out[5] == !display_on_out ##1 !bus_data_oe_n_out || rd_n_s;
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  property p_rmw_read;
    rd_data && rmw_out |=> $stable(column_out) && bus_data_out == $past(ram_rdata);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("column moved on modify read");

  property p_rmw_write;
    wr_data && rmw_out && column_out < lcdcd_pkg::COL_MAX |=> column_out == $past(column_out) + 8'h01;
  endproperty
  a_rmw_write: assert property (p_rmw_write) else $error("column not advanced on write");

  property p_ind_lock;
    wr_cmd && state_reg == lcdcd_pkg::LCDCD_WAIT_IND
      |=> state_reg == lcdcd_pkg::LCDCD_IDLE && $stable(display_on_out)
          && indicator_blink_out == $past(byte_s[1:0]);
  endproperty
  a_ind_lock: assert property (p_ind_lock) else $error("indicator byte not exclusive");

  property p_line_lock;
    wr_cmd && state_reg == lcdcd_pkg::LCDCD_WAIT_LINE
      |=> inverted_lines_out == $past(byte_s[4:0]) && $stable(page_out) && state_reg == lcdcd_pkg::LCDCD_IDLE;
  endproperty
  a_line_lock: assert property (p_line_lock) else $error("line count byte not exclusive");

  property p_volt;
    wr_cmd && state_reg == lcdcd_pkg::LCDCD_WAIT_VOLT
      |=> top_drive_voltage_out == $past(byte_s[5:0]) && state_reg == lcdcd_pkg::LCDCD_IDLE;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage level byte wrong");

  property p_nop;
    idle_cmd && byte_s == lcdcd_pkg::OP_NOP_V
      |=> $stable(column_out) && $stable(display_on_out) && $stable(rmw_out) && $stable(state_reg);
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state");

  property p_psave;
    idle_cmd && byte_s == 8'hA5 && !display_on_out
      |=> (standby_out == indicator_on_out) && (sleep_out == !indicator_on_out);
  endproperty
  a_psave: assert property (p_psave) else $error("power save not entered");

  c_rmw: cover property (wr_data && rmw_out);
  c_ind: cover property (state_reg == lcdcd_pkg::LCDCD_WAIT_IND ##[1:100] state_reg == lcdcd_pkg::LCDCD_IDLE);
  c_sleep: cover property (sleep_out);
  c_data_rd: cover property (rd_data ##1 !bus_data_oe_n_out);
endmodule : lcdcd_decoder
`default_nettype wire

/* File: testbench/lcdcd_host.sv */
/*
  Host microcontroller model for the parallel port of the command decoder.
  Assumes the device samples pins through two flops, so every level is held
  several clocks around each strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdcd_host (
  // clock
  input wire logic clk_sys_in,
  // host pins
  output logic [7:0] bus_data_out,
  output logic cmd_data_select_out,
  output logic rd_n_out,
  output logic wr_n_out,
  // device answer
  input wire logic [7:0] bus_data_in
);
  initial begin
    bus_data_out = 8'h00;
    cmd_data_select_out = 1'b0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
  end

  // one transfer: 3 clocks setup, 5 low, 5 high; test opcodes are never sent
  task automatic xfer(input logic sel, input logic rd, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_in);
    cmd_data_select_out <= sel;
    bus_data_out <= d;
    repeat (3) @(posedge clk_sys_in);
    if (rd) begin
      rd_n_out <= 1'b0;
    end else begin
      wr_n_out <= 1'b0;
    end
    repeat (5) @(posedge clk_sys_in);
    q = bus_data_in;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    // released bus must not keep showing the old byte
    bus_data_out <= ~d;
    repeat (5) @(posedge clk_sys_in);
  endtask : xfer
endmodule : lcdcd_host
`default_nettype wire

/* File: testbench/tb_lcd_driver_command_decoder.sv */
/*
  Self-checking bench for the command decoder, driven by the host model.
  Assumes the decoder settles each command well within one host transfer.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_driver_command_decoder;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] data_pin, dev_rdata, q, d, c, snap;
  logic sel_pin, rd_n_pin, wr_n_pin, dev_oe_n, b, es, ed;
  logic disp, segr, pinv, allon, bias, rmw, comr, linv, indon, slp, stby;
  logic [6:0] sl;
  logic [3:0] pg;
  logic [7:0] col;
  logic [2:0] pwr, rat;
  logic [5:0] vlt;
  logic [4:0] nl;
  logic [1:0] blk;
  logic [31:0] seed = 32'h03A1B6F4;
  logic [31:0] r;
  int error_cnt = 0;
  int total_checks = 0;

  initial forever #4 clk_sys_in = ~clk_sys_in;

  lcdcd_host lcdcd_host_i (.clk_sys_in(clk_sys_in), .bus_data_out(data_pin), .cmd_data_select_out(sel_pin),
    .rd_n_out(rd_n_pin), .wr_n_out(wr_n_pin), .bus_data_in(dev_rdata));

  lcdcd_decoder lcdcd_decoder_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .bus_data_in(data_pin),
    .cmd_data_select_in(sel_pin), .rd_n_in(rd_n_pin), .wr_n_in(wr_n_pin), .bus_data_out(dev_rdata),
    .bus_data_oe_n_out(dev_oe_n), .display_on_out(disp), .start_line_out(sl), .page_out(pg),
    .column_out(col), .segment_reverse_out(segr), .pixel_invert_out(pinv), .all_on_out(allon),
    .bias_ninth_out(bias), .rmw_out(rmw), .common_reverse_out(comr), .power_ctrl_out(pwr),
    .resistor_ratio_out(rat), .top_drive_voltage_out(vlt), .line_inversion_out(linv),
    .inverted_lines_out(nl), .indicator_on_out(indon), .indicator_blink_out(blk), .sleep_out(slp),
    .standby_out(stby));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // column step wraps after the last column
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return (v == lcdcd_pkg::COL_MAX) ? 8'h00 : v + 8'h01;
  endfunction : nxt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic s, input logic [7:0] v);
    logic [7:0] x;
    lcdcd_host_i.xfer(s, 1'b0, v, x);
  endtask : wr

  task automatic rd(input logic s, output logic [7:0] v);
    lcdcd_host_i.xfer(s, 1'b1, rnd(), v);
  endtask : rd

  task automatic setcol(input logic [7:0] v);
    wr(1'b0, {4'h1, v[7:4]});
    wr(1'b0, {4'h0, v[3:0]});
  endtask : setcol

  task automatic end_sim();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    chk(vlt, 32'h20);
    chk(disp, 32'h0);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      b = r[0];
      wr(1'b0, 8'hAE | b); chk(disp, b);
      wr(1'b0, 8'hA0 | b); chk(segr, b);
      wr(1'b0, 8'hA6 | b); chk(pinv, b);
      wr(1'b0, 8'hA2 | b); chk(bias, b);
      wr(1'b0, {4'hC, b, r[3:1]}); chk(comr, b);
      wr(1'b0, {3'b011, r[9:8], r[6:4]});
      wr(1'b0, {3'b010, r[10], r[3:0]}); chk(sl, r[6:0]);
      wr(1'b0, {4'hB, r[15:12]}); chk(pg, r[15:12]);
      c = (i == 0) ? 8'h83 : r[23:16] % 8'h84;
      setcol(c); chk(col, c);
      wr(1'b0, {5'b00101, r[26:24]}); chk(pwr, r[26:24]);
      wr(1'b0, {5'b00100, r[29:27]}); chk(rat, r[29:27]);
      d = rnd();
      wr(1'b1, d); chk(col, nxt(c));
      setcol(c);
      rd(1'b1, q); chk(q, d);
      chk(col, nxt(c));
      rd(1'b0, q); chk(q, {1'b0, b, ~b, 5'h00});
      chk(dev_oe_n, 1'b1);
    end
    wr(1'b0, 8'hE0); chk(rmw, 1'b1);
    setcol(c);
    rd(1'b1, q); chk(col, c);
    wr(1'b1, ~q); chk(col, nxt(c));
    wr(1'b0, 8'hEE); chk(rmw, 1'b0);
    wr(1'b0, 8'h81);
    wr(1'b0, 8'hC5); chk({comr, vlt}, {b, 6'h05});
    wr(1'b0, 8'h2B); chk(pwr, 3'h3);
    wr(1'b0, 8'hAD); chk(indon, 1'b1);
    wr(1'b0, {7'b1010111, ~b}); chk({disp, blk}, {b, 1'b1, ~b});
    wr(1'b0, 8'hAC); chk(indon, 1'b0);
    wr(1'b0, 8'hDD); chk(linv, 1'b1);
    wr(1'b0, 8'hB7); chk({pg, nl}, {r[15:12], 5'h17});
    wr(1'b0, 8'hD3); chk(linv, 1'b0);
    snap = {disp, segr, pinv, bias, comr, pg[2:0]};
    wr(1'b0, 8'hE3); chk({disp, segr, pinv, bias, comr, pg[2:0]}, snap);
    chk(col, nxt(c));
    wr(1'b0, 8'hAE);
    wr(1'b0, 8'hA5); chk({allon, slp, stby}, 3'b110);
    wr(1'b0, 8'hAD);
    wr(1'b0, 8'h01); chk({slp, stby}, 2'b01);
    // internal reset drops the indicator, so standby falls back to sleep
    wr(1'b0, 8'hE2);
    chk({slp, stby, vlt, pg, col}, {2'b10, lcdcd_pkg::RST_VOLT, lcdcd_pkg::RST_PAGE, lcdcd_pkg::RST_COL});
    wr(1'b0, 8'hA4); chk({allon, slp, stby}, 3'b000);
    end_sim();
  end
endmodule : tb_lcd_driver_command_decoder
`default_nettype wire
